// ---- rtl/core_timing_pkg.sv ----
package core_timing_pkg;

  // Oscillator period and the state that two periods make
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PHASES_PER_STATE = 2;
  localparam logic PHASE_FIRST = 1'b0;
  localparam logic PHASE_SECOND = 1'b1;

  // Peripheral cycle: six states, indices 0..5 name S1..S6
  localparam int unsigned STATE_W = 3;
  localparam logic [2:0] STATE_FIRST = 3'h0;
  localparam logic [2:0] STATE_LAST = 3'h5;
  localparam logic [2:0] STATE_NUM_BASE = 3'h1;
  // Capture counter array slot: state 5, phase 2
  localparam logic [2:0] CAPTURE_STATE = 3'h4;
  localparam logic CAPTURE_PHASE = PHASE_SECOND;

  // Fetch geometry
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PAGE_LSB = 8;
  localparam int unsigned PAGE_W = ADDR_W - PAGE_LSB;
  localparam logic [1:0] FETCH_STATES_SHORT = 2'h1;
  localparam logic [1:0] FETCH_STATES_LONG = 2'h2;
  localparam logic [1:0] BYTES_ONCHIP = 2'h2;
  localparam logic [1:0] BYTES_EXT = 2'h1;

  // Instruction completion rates, in states
  localparam int unsigned WAIT_W = 2;
  localparam logic [2:0] INSTR_STATES_ONCHIP = 3'h1;
  localparam logic [2:0] INSTR_STATES_EXT = 3'h2;
  localparam logic [2:0] ALE_EXTRA_STATES = 3'h1;

  // Chip reset stretch after the pin or the watchdog lets go
  localparam int unsigned RESET_HOLD_NS = 64;
  localparam int unsigned RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_DOWN = 2'b10
  } power_mode_t;

  // One clock slot of the peripheral cycle
  typedef struct packed {
    logic [STATE_W-1:0] stateIdx;
    logic phase;
    logic stateEnd;
    logic cycleEnd;
  } slot_t;

  // Fetch request from the instruction sequencer
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic onChip;
    logic pageMode;
  } fetch_req_t;

  // What one fetch puts on the code bus
  typedef struct packed {
    logic [CODE_W-1:0] word;
    logic [1:0] bytes;
  } code_beat_t;

endpackage

// ---- rtl/chip_reset_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module chip_reset_gen
  import core_timing_pkg::*;
#(
  parameter int unsigned HOLD = RESET_HOLD_CYCLES
)
(
  // Clock and pin reset
  input wire logic clk,
  input wire logic rst,
  // Watchdog expiry, one-cycle pulse
  input wire logic wdtTimeout,
  // Stretched chip reset
  output logic chipRst
);

  localparam int unsigned CNT_W = $clog2(HOLD + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(HOLD - 1);
  localparam logic [CNT_W-1:0] ZERO = '0;

  logic [CNT_W-1:0] cnt_q; // Cycles of reset still to run
  logic rst_q;             // Reset output flop

  // Pin or watchdog starts the stretch; a watchdog pulse during
  // the stretch restarts it so no expiry is shortened
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= LOAD;
      rst_q <= 1'b1;
    end
    else if (wdtTimeout)
    begin
      cnt_q <= LOAD;
      rst_q <= 1'b1;
    end
    else if (cnt_q != ZERO)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
    else
    begin
      rst_q <= 1'b0;
    end
  end

  assign chipRst = rst_q;

endmodule
`default_nettype wire

// ---- rtl/fetch_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module fetch_timer
  import core_timing_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic chipRst,
  // Processor clock gate
  input wire logic cpuClkEn,
  // Fetch request
  input wire logic reqValid,
  input wire fetch_req_t req,
  output logic reqReady,
  // Memory data
  input wire logic [CODE_W-1:0] onChipWord,
  input wire logic [BYTE_W-1:0] extByte,
  // Code bus
  output code_beat_t beat,
  output logic beatValid
);

  // Fetch length in clocks: states times two phases
  function automatic logic [2:0] fetchClocks(input logic onChip,
    input logic pageMode, input logic samePage);
    logic [1:0] states;
    states = (onChip || (pageMode && samePage)) ?
      FETCH_STATES_SHORT : FETCH_STATES_LONG;
    return {states, 1'b0};
  endfunction

  logic busy_q;                    // Fetch in progress
  logic [2:0] left_q;              // Clocks still to go
  logic onChip_q;                  // Source of fetch in flight
  logic [PAGE_W-1:0] page_q;       // Page of previous fetch
  logic pageValid_q;               // page_q holds a real fetch
  logic samePage;                  // Request hits previous page
  logic take;                      // Request accepted
  logic finish;                    // Last clock of the fetch
  code_beat_t beat_q;
  logic beatValid_q;

  assign samePage = pageValid_q &&
    (req.addr[ADDR_W-1:PAGE_LSB] == page_q);
  assign reqReady = !busy_q && cpuClkEn && !chipRst;
  assign take = reqValid && reqReady;
  assign finish = busy_q && cpuClkEn && (left_q == 3'h1);

  // RL4 page mode timing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      left_q <= 3'h0;
      onChip_q <= 1'b0;
    end
    else if (chipRst)
    begin
      busy_q <= 1'b0;
      left_q <= 3'h0;
    end
    else if (take)
    begin
      busy_q <= 1'b1;
      onChip_q <= req.onChip;
      left_q <= fetchClocks(req.onChip, req.pageMode, samePage);
    end
    else if (finish)
    begin
      busy_q <= 1'b0;
      left_q <= 3'h0;
    end
    else if (busy_q && cpuClkEn)
    begin
      left_q <= left_q - 3'h1;
    end
  end

  // Remember the page of each fetch for the next compare
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_q <= '0;
      pageValid_q <= 1'b0;
    end
    else if (chipRst)
    begin
      pageValid_q <= 1'b0;
    end
    else if (take)
    begin
      page_q <= req.addr[ADDR_W-1:PAGE_LSB];
      pageValid_q <= 1'b1;
    end
  end

  // RL5 word or byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      beat_q <= '0;
      beatValid_q <= 1'b0;
    end
    else
    begin
      beatValid_q <= finish && !chipRst;
      if (finish)
      begin
        beat_q.word <= onChip_q ? onChipWord :
          {{(CODE_W-BYTE_W){1'b0}}, extByte};
        beat_q.bytes <= onChip_q ? BYTES_ONCHIP : BYTES_EXT;
      end
    end
  end

  assign beat = beat_q;
  assign beatValid = beatValid_q;

endmodule
`default_nettype wire

// ---- rtl/core_clock_ctrl.sv ----
// How it works
// RL1 - State is two clocks, two phases
// RL2 - Peripheral cycle is six state slots
// RL3 - Capture counter ticks once at STATE5_PHASE2_SLOT
// RL4 - Same-page external fetch in page mode: one state
// RL5 - On-chip fetch two bytes, external one
// RL6 - Completion: one state on-chip, two external
// RL7 - Idle stops processor clock, peripherals run
// RL8 - Powerdown halts oscillator, all logic static
// RL9 - Enabled interrupt or reset leaves low power
// RL10 - Reset pin or watchdog starts chip reset
// RL11 - Peripheral timing from own state sequencer
// RL12 - Chip reset restarts at S1 phase 1
`timescale 1ns/1ns
`default_nettype none
module core_clock_ctrl
  import core_timing_pkg::*;
#(
  parameter int unsigned RESET_HOLD = RESET_HOLD_CYCLES
)
(
  // Oscillator clock and reset pin
  input wire logic clk,
  input wire logic rst,
  // Watchdog expiry pulse
  input wire logic wdtTimeout,
  // Power mode requests from the processor
  input wire logic idleReq,
  input wire logic pdReq,
  // Enabled interrupt pending
  input wire logic wakeIrq,
  // Pipeline status from the execution unit
  input wire logic pipeFull,
  input wire logic execExternal,
  input wire logic [WAIT_W-1:0] waitStates,
  input wire logic aleExtend,
  // Instruction fetch port
  input wire logic fetchValid,
  input wire fetch_req_t fetchReq,
  output logic fetchReady,
  input wire logic [CODE_W-1:0] onChipWord,
  input wire logic [BYTE_W-1:0] extByte,
  // Code bus to the execution unit
  output code_beat_t codeBeat,
  output logic codeValid,
  // State timing to peripherals
  output slot_t slot,
  output logic [STATE_W-1:0] stateNum,
  output logic phaseNum,
  output logic periphCycleStart,
  output logic captureTick,
  // Clock gates and mode
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic oscRun,
  output power_mode_t powerMode,
  // Chip reset and completion strobe
  output logic chipRst,
  output logic instrDone
);

  // Number of states one instruction needs at full pipeline
  function automatic logic [2:0] instrStates(input logic ext,
    input logic [WAIT_W-1:0] waits, input logic ale);
    logic [2:0] n;
    n = ext ? INSTR_STATES_EXT : INSTR_STATES_ONCHIP;
    if (ext)
    begin
      n = n + 3'(waits);
      if (ale)
      begin
        n = n + ALE_EXTRA_STATES;
      end
    end
    return n;
  endfunction

  // Sequencer registers
  logic phase_q;                 // Current phase
  logic [STATE_W-1:0] state_q;   // Current state index
  logic capture_q;               // Capture slot strobe
  logic cycleStart_q;            // First slot of a cycle
  // Power mode
  power_mode_t mode_q;           // Current mode
  power_mode_t mode_d;           // Next mode
  // Completion counter
  logic [2:0] instrCnt_q;        // States since last completion
  logic instrDone_q;             // Completion strobe
  // Derived slot flags
  logic stateEnd;                // Last clock of a state
  logic cycleEnd;                // Last clock of a cycle
  logic seqRun;                  // Sequencer may advance
  logic [2:0] need;              // States wanted per instruction

  // Chip reset from pin or watchdog
  // RL10 pin or watchdog
  chip_reset_gen #(
    .HOLD(RESET_HOLD)
  ) u_reset (
    .clk(clk),
    .rst(rst),
    .wdtTimeout(wdtTimeout),
    .chipRst(chipRst)
  );

  // Slot decoding from the counters
  assign stateEnd = (phase_q == PHASE_SECOND);
  assign cycleEnd = stateEnd && (state_q == STATE_LAST);

  // RL8 oscillator halted
  // In powerdown nothing advances, so every counter holds still
  assign seqRun = (mode_q != PWR_DOWN);

  // RL1 two phase state
  // RL12 restart at S1P1
  // Phase toggles every clock while the oscillator runs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= PHASE_FIRST;
    end
    else if (chipRst)
    begin
      phase_q <= PHASE_FIRST;
    end
    else if (seqRun)
    begin
      phase_q <= ~phase_q;
    end
  end

  // RL2 six state cycle
  // RL11 own sequencing
  // State index steps at the end of each state and wraps after S6
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= STATE_FIRST;
    end
    else if (chipRst)
    begin
      state_q <= STATE_FIRST;
    end
    else if (seqRun && stateEnd)
    begin
      if (state_q == STATE_LAST)
      begin
        state_q <= STATE_FIRST;
      end
      else
      begin
        state_q <= state_q + 3'h1;
      end
    end
  end

  // RL3 capture tick
  // Registered a clock early so the strobe sits exactly in STATE5_PHASE2_SLOT
  // and peripherals see a clean flop output, not a decode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      capture_q <= 1'b0;
      cycleStart_q <= 1'b1;
    end
    else if (chipRst)
    begin
      capture_q <= 1'b0;
      cycleStart_q <= 1'b1;
    end
    else if (seqRun)
    begin
      // Next clock is STATE5_PHASE2_SLOT when we now stand in S5P1
      capture_q <= (state_q == CAPTURE_STATE) &&
        (phase_q == PHASE_FIRST);
      // Next clock is S1P1 when this is the cycle's last clock
      cycleStart_q <= cycleEnd;
    end
    else
    begin
      // Frozen: strobes drop so no tick repeats while static
      capture_q <= 1'b0;
      cycleStart_q <= 1'b0;
    end
  end

  // Power mode next state
  // RL9 wake on irq or reset
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      PWR_RUN:
      begin
        // Powerdown wins when both are asked in one cycle
        if (pdReq)
        begin
          mode_d = PWR_DOWN;
        end
        else if (idleReq)
        begin
          mode_d = PWR_IDLE;
        end
      end
      PWR_IDLE:
      begin
        if (wakeIrq)
        begin
          mode_d = PWR_RUN;
        end
      end
      PWR_DOWN:
      begin
        // Interrupt logic must stay awake to see this pin
        if (wakeIrq)
        begin
          mode_d = PWR_RUN;
        end
      end
      default:
      begin
        mode_d = PWR_RUN;
      end
    endcase
  end

  // Mode register; chip reset always returns to run
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= PWR_RUN;
    end
    else if (chipRst)
    begin
      mode_q <= PWR_RUN;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // RL7 idle gating
  // Clock enables rather than gated clocks: the gating cell sits
  // in the clock tree, this block only says when it may pass
  assign cpuClkEn = (mode_q == PWR_RUN);
  assign periphClkEn = (mode_q != PWR_DOWN);
  // RL8 oscillator halted
  assign oscRun = (mode_q != PWR_DOWN);
  assign powerMode = mode_q;

  // States wanted for the instruction now executing
  assign need = instrStates(execExternal, waitStates, aleExtend);

  // RL6 completion rate
  // Counts states while the processor clock runs; a partly filled
  // pipeline restarts the count so no early completion is claimed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      instrCnt_q <= 3'h0;
      instrDone_q <= 1'b0;
    end
    else if (chipRst)
    begin
      instrCnt_q <= 3'h0;
      instrDone_q <= 1'b0;
    end
    else if (cpuClkEn && stateEnd)
    begin
      if (!pipeFull)
      begin
        instrCnt_q <= 3'h0;
        instrDone_q <= 1'b0;
      end
      else if (instrCnt_q + 3'h1 >= need)
      begin
        instrCnt_q <= 3'h0;
        instrDone_q <= 1'b1;
      end
      else
      begin
        instrCnt_q <= instrCnt_q + 3'h1;
        instrDone_q <= 1'b0;
      end
    end
    else
    begin
      instrDone_q <= 1'b0;
    end
  end

  // RL4 page mode fetch
  // RL5 code bus width
  fetch_timer u_fetch (
    .clk(clk),
    .rst(rst),
    .chipRst(chipRst),
    .cpuClkEn(cpuClkEn),
    .reqValid(fetchValid),
    .req(fetchReq),
    .reqReady(fetchReady),
    .onChipWord(onChipWord),
    .extByte(extByte),
    .beat(codeBeat),
    .beatValid(codeValid)
  );

  // Slot bundle for peripherals
  // One assignment for the whole bundle keeps a single driver
  assign slot = '{stateIdx: state_q, phase: phase_q,
    stateEnd: stateEnd, cycleEnd: cycleEnd};
  // Human numbering: S1..S6, P1..P2 shown as 0/1
  assign stateNum = state_q + STATE_NUM_BASE;
  assign phaseNum = phase_q;
  assign periphCycleStart = cycleStart_q;
  assign captureTick = capture_q;
  assign instrDone = instrDone_q;

endmodule
`default_nettype wire

// ---- testbench/core_clock_ctrl_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_clock_ctrl_checker
  import core_timing_pkg::*;
#(
  parameter int unsigned RESET_HOLD = RESET_HOLD_CYCLES
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic chipRst,
  input wire logic wdtTimeout,
  // Power control
  input wire logic idleReq,
  input wire logic pdReq,
  input wire logic wakeIrq,
  input wire power_mode_t powerMode,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic oscRun,
  // Fetch and completion
  input wire logic fetchValid,
  input wire fetch_req_t fetchReq,
  input wire logic fetchReady,
  input wire logic codeValid,
  input wire logic instrDone,
  // Sequencer
  input wire slot_t slot,
  input wire logic captureTick
);
  logic [PAGE_W-1:0] page_q; // Page of the last accepted fetch
  logic pageOk_q; // Page known; lost on reset
  logic [7:0] hold_q; // Clocks spent in chip reset
  logic take;
  logic fastFetch;

  assign take = fetchValid && fetchReady;
  assign fastFetch = fetchReq.onChip || (fetchReq.pageMode && pageOk_q
    && fetchReq.addr[ADDR_W-1:PAGE_LSB] == page_q);

  // Page tracker, any fetch source counts; chip reset forgets it
  always_ff @(posedge clk or posedge rst)
    if (rst)
      pageOk_q <= 1'b0;
    else if (chipRst)
      pageOk_q <= 1'b0;
    else if (take)
      pageOk_q <= 1'b1;
  always_ff @(posedge clk)
    if (take)
      page_q <= fetchReq.addr[ADDR_W-1:PAGE_LSB];

  // Reset stretch length, two clocks of slack for the release edge
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold_q <= 8'h00;
    else if (chipRst)
      hold_q <= hold_q + 8'h01;
    else
      hold_q <= 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || chipRst);

  a_phase_alternates: assert property (
    oscRun |=> slot.phase != $past(slot.phase)) else $error("phase stuck");
  a_state_steps: assert property (
    oscRun && slot.phase |=> slot.stateIdx == ($past(slot.stateIdx)
    == STATE_LAST ? STATE_FIRST : $past(slot.stateIdx) + 3'h1))
    else $error("state order wrong");
  a_tick_slot: assert property (
    captureTick |-> slot.stateIdx == CAPTURE_STATE && slot.phase)
    else $error("tick outside STATE5_PHASE2_SLOT");
  // A wake straight into a frozen STATE5_PHASE2_SLOT owes no second tick
  a_tick_due: assert property (
    oscRun && $past(oscRun) && slot.stateIdx == CAPTURE_STATE
    && slot.phase |-> captureTick)
    else $error("tick missing");
  a_tick_once: assert property (
    captureTick |=> !captureTick [*8]) else $error("tick too often");
  a_restart_s1p1: assert property (
    disable iff (rst) $fell(chipRst) |-> slot.stateIdx == STATE_FIRST
    && slot.phase == PHASE_FIRST) else $error("no restart at S1P1");
  a_wdt_reset: assert property (
    disable iff (rst) wdtTimeout |=> chipRst) else $error("no chip reset");
  a_reset_hold: assert property (
    disable iff (rst) hold_q <= 8'(RESET_HOLD + 2))
    else $error("chip reset too long");
  a_idle_gates: assert property (
    powerMode == PWR_IDLE |-> !cpuClkEn && periphClkEn && oscRun)
    else $error("idle gating wrong");
  a_idle_entry: assert property (
    idleReq && !pdReq && powerMode == PWR_RUN |=> powerMode == PWR_IDLE)
    else $error("idle not entered");
  a_pd_entry: assert property (
    pdReq && powerMode == PWR_RUN |=> !oscRun && !periphClkEn && !cpuClkEn)
    else $error("powerdown not entered");
  a_pd_frozen: assert property (
    !oscRun && !wakeIrq |=> $stable(slot) && !captureTick)
    else $error("logic moved in powerdown");
  a_wake_run: assert property (
    wakeIrq && powerMode != PWR_RUN |=> powerMode == PWR_RUN && cpuClkEn)
    else $error("no wake");
  a_fetch_fast: assert property (
    take && fastFetch |=> !codeValid [*2] ##1 codeValid)
    else $error("short fetch timing");
  a_fetch_slow: assert property (
    take && !fastFetch |=> !codeValid [*4] ##1 codeValid)
    else $error("long fetch timing");
  a_done_gap: assert property (
    instrDone |=> !instrDone) else $error("two completions in a state");

  c_capture: cover property (captureTick);
  c_idle: cover property (powerMode == PWR_IDLE);
  c_down: cover property (powerMode == PWR_DOWN);
  c_page: cover property (take && fastFetch && !fetchReq.onChip);
endmodule

bind core_clock_ctrl core_clock_ctrl_checker #(.RESET_HOLD(RESET_HOLD)) chk (
  .clk, .rst, .chipRst, .wdtTimeout, .idleReq, .pdReq, .wakeIrq, .powerMode,
  .cpuClkEn, .periphClkEn, .oscRun, .fetchValid, .fetchReq, .fetchReady,
  .codeValid, .instrDone, .slot, .captureTick);
`default_nettype wire

// ---- testbench/code_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module code_mem_model
  import core_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch handshake seen at the core
  input wire logic fetchValid,
  input wire logic fetchReady,
  input wire fetch_req_t fetchReq,
  input wire logic codeValid,
  // Memory data to the core
  output logic [CODE_W-1:0] onChipWord,
  output logic [BYTE_W-1:0] extByte
);
  logic [7:0] addr_q; // Low address of the fetch in flight
  logic busy_q;
  logic [7:0] junk_q; // Idle pattern, so stale data never looks valid

  // Memory busy from acceptance to the code beat
  // Junk pattern starts from a known seed so it never stays unknown
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      busy_q <= 1'b0;
      junk_q <= 8'h5a;
    end
    else
    begin
      junk_q <= ~junk_q + 8'h35;
      if (fetchValid && fetchReady)
        busy_q <= 1'b1;
      else if (codeValid)
        busy_q <= 1'b0;
    end
  always_ff @(posedge clk)
    if (fetchValid && fetchReady)
      addr_q <= fetchReq.addr[7:0];

  // Data only while a fetch is open
  assign onChipWord = busy_q ? {addr_q ^ 8'h3c, addr_q} : {junk_q, ~junk_q};
  assign extByte = busy_q ? addr_q ^ 8'hc3 : junk_q;
endmodule
`default_nettype wire

// ---- testbench/core_clock_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_clock_ctrl_tb
  import core_timing_pkg::*;
;
  localparam int HOLD = 2; // Short reset stretch keeps the run brief
  // Stimulus
  logic clk = 1'b0, rst = 1'b1, wdtTimeout = 1'b0, idleReq = 1'b0;
  logic pdReq = 1'b0, wakeIrq = 1'b0, pipeFull = 1'b0;
  logic execExternal = 1'b0, aleExtend = 1'b0, fetchValid = 1'b0;
  logic [WAIT_W-1:0] waitStates = '0;
  fetch_req_t fetchReq = '0;
  // Observed
  logic [CODE_W-1:0] onChipWord;
  logic [BYTE_W-1:0] extByte;
  logic fetchReady, codeValid, periphCycleStart, captureTick, cpuClkEn;
  logic periphClkEn, oscRun, chipRst, instrDone, phaseNum;
  logic [STATE_W-1:0] stateNum;
  code_beat_t codeBeat;
  slot_t slot;
  power_mode_t powerMode;
  int miscompares = 0, testsRun = 0;

  always #4 clk = ~clk;

  core_clock_ctrl #(.RESET_HOLD(HOLD)) uut (.clk, .rst, .wdtTimeout,
    .idleReq, .pdReq, .wakeIrq, .pipeFull, .execExternal, .waitStates,
    .aleExtend, .fetchValid, .fetchReq, .fetchReady, .onChipWord, .extByte,
    .codeBeat, .codeValid, .slot, .stateNum, .phaseNum, .periphCycleStart,
    .captureTick, .cpuClkEn, .periphClkEn, .oscRun, .powerMode, .chipRst,
    .instrDone);
  code_mem_model mem (.clk, .rst, .fetchValid, .fetchReady, .fetchReq,
    .codeValid, .onChipWord, .extByte);

  // Inputs move just after the edge, outputs are settled there
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bounded wait for chip reset to end, then expect S1P1
  task automatic wait_release;
    int n;
    for (n = 0; n < 20 && chipRst !== 1'b0; n++)
      step();
    chk(n, HOLD);
    chk({stateNum, phaseNum, periphCycleStart}, 5'h05);
  endtask

  // Two full peripheral cycles, slot by slot
  task automatic t_sequence;
    for (int i = 0; i < 24; i++)
    begin
      chk({stateNum, phaseNum, captureTick, periphCycleStart}, {3'(i / 2 % 6
        + 1), 1'(i % 2), 1'(i % 12 == 9), 1'(i % 12 == 0)});
      step();
    end
  endtask

  // One fetch; entered in a ready cycle gives back-to-back traffic
  task automatic fetch(input logic [23:0] a, input logic on,
    input logic pm, input int lat);
    int n;
    fetchReq = '{addr: a, onChip: on, pageMode: pm};
    fetchValid = 1'b1;
    for (n = 0; n < 20 && fetchReady !== 1'b1; n++)
      step();
    step();
    fetchValid = 1'b0;
    for (n = 1; n < 20 && codeValid !== 1'b1; n++)
      step();
    chk(n, lat);
    chk(codeBeat.bytes, on ? BYTES_ONCHIP : BYTES_EXT);
    chk(codeBeat.word[7:0], on ? a[7:0] : a[7:0] ^ 8'hc3);
    if (on)
      chk(codeBeat.word[15:8], a[7:0] ^ 8'h3c);
  endtask

  // Completions in twelve clocks with a full pipeline
  task automatic count_done(input logic ext, input logic [WAIT_W-1:0] ws,
    input logic ale, input int exp);
    int n;
    n = 0;
    execExternal = ext;
    waitStates = ws;
    aleExtend = ale;
    pipeFull = 1'b1;
    step(8);
    repeat (12)
    begin
      if (instrDone === 1'b1)
        n++;
      step();
    end
    chk(n, exp);
  endtask

  task automatic t_idle;
    int n;
    n = 0;
    pipeFull = 1'b0;
    step(2);
    idleReq = 1'b1;
    step();
    idleReq = 1'b0;
    chk({cpuClkEn, periphClkEn, oscRun, fetchReady}, 4'h6);
    repeat (12)
    begin
      if (captureTick === 1'b1)
        n++;
      step();
    end
    chk(n, 1);
    wakeIrq = 1'b1;
    step();
    wakeIrq = 1'b0;
    chk({powerMode, cpuClkEn}, {PWR_RUN, 1'b1});
  endtask

  task automatic t_powerdown;
    slot_t held;
    // Powerdown wins over a same-cycle idle request
    pdReq = 1'b1;
    idleReq = 1'b1;
    step();
    pdReq = 1'b0;
    idleReq = 1'b0;
    held = slot;
    chk({powerMode, oscRun, periphClkEn}, {PWR_DOWN, 2'b00});
    step(20);
    chk({slot, captureTick}, {held, 1'b0});
    wakeIrq = 1'b1;
    step();
    wakeIrq = 1'b0;
    chk({powerMode, oscRun}, {PWR_RUN, 1'b1});
    // Second entry, left by the reset pin
    pdReq = 1'b1;
    step();
    pdReq = 1'b0;
    rst = 1'b1;
    step();
    rst = 1'b0;
    chk({powerMode, chipRst}, {PWR_RUN, 1'b1});
    wait_release();
  endtask

  task automatic t_watchdog;
    step(3);
    wdtTimeout = 1'b1;
    step();
    wdtTimeout = 1'b0;
    chk({chipRst, fetchReady}, 2'h2);
    wait_release();
  endtask

  // Main sequence
  initial
  begin
    step(5);
    rst = 1'b0;
    wait_release();
    t_sequence();
    fetch(24'h001234, 1'b1, 1'b0, 3);
    fetch(24'h001256, 1'b0, 1'b1, 3);
    fetch(24'h001300, 1'b0, 1'b1, 5);
    fetch(24'h00137f, 1'b0, 1'b0, 5);
    fetch(24'h001380, 1'b0, 1'b1, 3);
    count_done(1'b0, 2'h0, 1'b0, 6);
    count_done(1'b1, 2'h0, 1'b0, 3);
    count_done(1'b1, 2'h1, 1'b0, 2);
    count_done(1'b1, 2'h0, 1'b1, 2);
    t_idle();
    t_powerdown();
    t_watchdog();
    results();
  end

  // Hang guard, far beyond the roughly 180 clocks needed
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
